// ===== asp_defs.svh
/*
 Offsets, field positions, reset values and timing counts of the serial port controller.
 Assumes a 32-bit APB register bus and a 100 MHz pclk.
*/
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH

`define ASP_OFS_CTRL        12'h000
`define ASP_OFS_DATA        12'h004
`define ASP_OFS_CAL         12'h008
`define ASP_OFS_STATUS      12'h00C

`define ASP_CTRL_BURNOUT    0
`define ASP_CTRL_COMP       1
`define ASP_CTRL_CALSEL     2

`define ASP_WORD_W          24
`define ASP_CTRL_RST        24'h00_0000
`define ASP_PIN_RST         7'h36

`define ASP_CLK_NS          10
`define ASP_SCLK_HI_NS      20
`define ASP_SCLK_LO_NS      60
`define ASP_SCLK_HI_CYC     ((`ASP_SCLK_HI_NS + `ASP_CLK_NS - 1) / `ASP_CLK_NS)
`define ASP_SCLK_LO_CYC     ((`ASP_SCLK_LO_NS + `ASP_CLK_NS - 1) / `ASP_CLK_NS)

`endif

// ===== asp_pkg.sv
/*
 Types of the serial port controller.
 Assumes nothing beyond the compile order.
*/
package asp_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR, ST_DONE} asp_state_t;
    typedef enum logic [1:0] {TGT_CTRL, TGT_DATA, TGT_CAL} asp_tgt_t;
endpackage

// ===== asp_shift_if.sv
/*
 Carrier between frame control and the word shifter.
 Assumes both ends run on pclk.
*/
interface asp_shift_if #(parameter int WORD_W = 24);
    logic              load;
    logic [WORD_W-1:0] load_word;
    logic              rise;
    logic              fall;
    logic              sdi;
    logic              sdo;
    logic              done;
    logic [WORD_W-1:0] rx_word;
    modport ctl (output load, load_word, rise, fall, sdi, input sdo, done, rx_word);
    modport shf (input load, load_word, rise, fall, sdi, output sdo, done, rx_word);
endinterface

// ===== asp_shifter.sv
/*
 Word shifter: loads a word, shifts in on serial clock rise, presents the next bit on fall.
 Assumes rise and fall are single-cycle pulses in the pclk domain.
*/
module asp_shifter #(
    parameter int WORD_W = 24
) (
    // Clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // Frame control side
    asp_shift_if.shf   s
);
    localparam int CW = $clog2(WORD_W + 1);
    if (WORD_W < 2) begin : g_bad_word
        $error("WORD_W too small");
    end

    logic [WORD_W-1:0] sr_q, sr_d;
    logic [CW-1:0]     cnt_q, cnt_d;
    logic              sdo_q, sdo_d;
    logic              done_q, done_d;

    always_comb begin
        sr_d   = sr_q;
        cnt_d  = cnt_q;
        sdo_d  = sdo_q;
        done_d = done_q;
        if (s.load) begin
            sr_d   = s.load_word;
            sdo_d  = s.load_word[WORD_W-1];
            cnt_d  = '0;
            done_d = 1'b0;
        end else if (!done_q) begin
            if (s.rise) begin
                sr_d   = {sr_q[WORD_W-2:0], s.sdi};
                cnt_d  = cnt_q + CW'(1);
                done_d = (cnt_q == CW'(WORD_W - 1));
            end else if (s.fall && cnt_q != '0) begin
                sdo_d = sr_q[WORD_W-1];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sr_q   <= '0;
            cnt_q  <= '0;
            sdo_q  <= 1'b0;
            done_q <= 1'b0;
        end else begin
            sr_q   <= sr_d;
            cnt_q  <= cnt_d;
            sdo_q  <= sdo_d;
            done_q <= done_d;
        end
    end

    assign s.sdo     = sdo_q;
    assign s.done    = done_q;
    assign s.rx_word = sr_q;
endmodule

// ===== asp_serial_port.sv
/*
 Serial port control of a sigma-delta converter, with APB access to its registers.
 Assumes pins are asynchronous to pclk and the host keeps the master clock running.
*/
// Design decisions made here: register access over APB and the register offsets.
// Function
// - Strap high means self-clocking, device drives serial clock; low means clock is input.
// - Self-clocking: clock pulses start when either frame strobe goes low.
// - Self-clocking: clock released when strobe returns high or word is complete.
// - External clock may run continuously or in gapped batches; both accepted.
// - Select low targets control register; high targets data or calibration registers.
// - Filter sync input resets the digital filter state.
// - Control bit switches the burnout test current on channel one positive input.
// - Control bit switches the compensation current output.
`include "asp_defs.svh"
module asp_serial_port #(
    parameter int WORD_W  = `ASP_WORD_W,
    parameter int HI_CYC  = `ASP_SCLK_HI_CYC,
    parameter int LO_CYC  = `ASP_SCLK_LO_CYC
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial pins
    input  wire logic        mode_self_clock,
    input  wire logic        receive_frame_strobe_n,
    input  wire logic        transmit_frame_strobe_n,
    input  wire logic        register_select,
    input  wire logic        filter_sync_n,
    input  wire logic        sclk_i,
    output logic             sclk_o,
    output logic             sclk_oe_n,
    input  wire logic        sdata_i,
    output logic             sdata_o,
    output logic             sdata_oe_n,
    // Analog controls
    output logic             burnout_current_en,
    output logic             comp_current_en,
    output logic             filter_reset
);
    if (WORD_W < 2 || WORD_W > 32) begin : g_bad_word
        $error("WORD_W out of range");
    end
    if (HI_CYC < 1 || LO_CYC < 1 || HI_CYC > 255 || LO_CYC > 255) begin : g_bad_cyc
        $error("bad SCLK counts");
    end

    // Pin synchronisers: a change counts once second and third stages agree
    logic [6:0] pin_raw, s1_q, s2_q, s3_q, flt_q, flt_d;
    assign pin_raw = {sdata_i, sclk_i, filter_sync_n, register_select,
                      transmit_frame_strobe_n, receive_frame_strobe_n, mode_self_clock};
    for (genvar i = 0; i < 7; i++) begin : g_flt
        assign flt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : flt_q[i];
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q  <= `ASP_PIN_RST;
            s2_q  <= `ASP_PIN_RST;
            s3_q  <= `ASP_PIN_RST;
            flt_q <= `ASP_PIN_RST;
        end else begin
            s1_q  <= pin_raw;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            flt_q <= flt_d;
        end
    end
    logic self_f, rcv_stb_f, xmt_stb_f, sel_f, sync_f, sclk_f, sdi_f;
    assign {sdi_f, sclk_f, sync_f, sel_f, xmt_stb_f, rcv_stb_f, self_f} = flt_q;

    asp_shift_if #(.WORD_W(WORD_W)) sh ();
    asp_shifter #(.WORD_W(WORD_W)) u_shift (
        .pclk    (pclk),
        .presetn (presetn),
        .s       (sh)
    );

    asp_pkg::asp_state_t st_q, st_d;
    asp_pkg::asp_tgt_t   tgt_q, tgt_d;
    logic [WORD_W-1:0]   ctrl_q, ctrl_d, data_q, data_d, cal_q, cal_d;
    logic [7:0]          gcnt_q, gcnt_d;
    logic                sclk_q, sclk_d, sclk_oe_n_q, sclk_oe_n_d, sclk_prev_q;
    logic                sdo_q, sdo_oe_n_q, sdo_oe_n_d, frst_q;
    logic                pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0]         prdata_q, prdata_d;
    logic                ext_rise, ext_fall, gen_rise, gen_fall, active, start, apb_wr;

    function automatic logic map_hit(input logic [11:0] a);
        map_hit = (a == `ASP_OFS_CTRL) || (a == `ASP_OFS_DATA) ||
                  (a == `ASP_OFS_CAL)  || (a == `ASP_OFS_STATUS);
    endfunction

    assign active   = (st_q == asp_pkg::ST_RD) || (st_q == asp_pkg::ST_WR);
    assign ext_rise = !self_f && sclk_f && !sclk_prev_q;
    assign ext_fall = !self_f && !sclk_f && sclk_prev_q;
    assign gen_rise = self_f && active && !sclk_q && gcnt_q == 8'(LO_CYC - 1);
    assign gen_fall = self_f && active && sclk_q && gcnt_q == 8'(HI_CYC - 1);
    assign start    = (st_q == asp_pkg::ST_IDLE) && (!rcv_stb_f || !xmt_stb_f);
    assign apb_wr   = psel && penable && pwrite && pready_q;

    // Frame control and self clock generator
    always_comb begin
        st_d        = st_q;
        tgt_d       = tgt_q;
        gcnt_d      = gcnt_q;
        sclk_d      = 1'b1;
        sh.load     = 1'b0;
        sh.load_word = ctrl_q;
        if (!sel_f) begin
            tgt_d = asp_pkg::TGT_CTRL;
        end else if (ctrl_q[`ASP_CTRL_CALSEL]) begin
            tgt_d = asp_pkg::TGT_CAL;
        end else begin
            tgt_d = asp_pkg::TGT_DATA;
        end
        if (!start) begin
            tgt_d = tgt_q;
        end
        unique case (tgt_d)
            asp_pkg::TGT_DATA: sh.load_word = data_q;
            asp_pkg::TGT_CAL:  sh.load_word = cal_q;
            default:           sh.load_word = ctrl_q;
        endcase
        unique case (st_q)
            asp_pkg::ST_IDLE: begin
                gcnt_d = '0;
                if (start) begin
                    sh.load = 1'b1;
                    st_d    = !rcv_stb_f ? asp_pkg::ST_RD : asp_pkg::ST_WR;
                end
            end
            asp_pkg::ST_RD, asp_pkg::ST_WR: begin
                sclk_d = sclk_q;
                if (gen_rise || gen_fall) begin
                    gcnt_d = '0;
                    sclk_d = !sclk_q;
                end else begin
                    gcnt_d = gcnt_q + 8'd1;
                end
                if ((st_q == asp_pkg::ST_RD && rcv_stb_f) || (st_q == asp_pkg::ST_WR && xmt_stb_f)) begin
                    st_d = asp_pkg::ST_IDLE;
                end else if (sh.done) begin
                    st_d = asp_pkg::ST_DONE;
                end
            end
            asp_pkg::ST_DONE: begin
                if (rcv_stb_f && xmt_stb_f) begin
                    st_d = asp_pkg::ST_IDLE;
                end
            end
        endcase
        sclk_oe_n_d = !(self_f && active && st_d != asp_pkg::ST_DONE && st_d != asp_pkg::ST_IDLE);
        sdo_oe_n_d  = !(st_d == asp_pkg::ST_RD);
    end
    assign sh.rise = self_f ? gen_rise : (ext_rise && active);
    assign sh.fall = self_f ? gen_fall : (ext_fall && active);
    assign sh.sdi  = sdi_f;

    // Register file: serial commit beats a same-cycle APB write
    always_comb begin
        ctrl_d = ctrl_q;
        data_d = data_q;
        cal_d  = cal_q;
        if (apb_wr && paddr == `ASP_OFS_CTRL) ctrl_d = pwdata[WORD_W-1:0];
        if (apb_wr && paddr == `ASP_OFS_DATA) data_d = pwdata[WORD_W-1:0];
        if (apb_wr && paddr == `ASP_OFS_CAL)  cal_d  = pwdata[WORD_W-1:0];
        if (st_q == asp_pkg::ST_WR && sh.done) begin
            unique case (tgt_q)
                asp_pkg::TGT_CTRL: ctrl_d = sh.rx_word;
                asp_pkg::TGT_CAL:  cal_d  = sh.rx_word;
                default:           data_d = data_q;
            endcase
        end
        pready_d  = psel && penable && !pready_q;
        pslverr_d = pready_d && !map_hit(paddr);
        prdata_d  = prdata_q;
        if (pready_d && !pwrite) begin
            unique case (paddr)
                `ASP_OFS_CTRL:   prdata_d = 32'(ctrl_q);
                `ASP_OFS_DATA:   prdata_d = 32'(data_q);
                `ASP_OFS_CAL:    prdata_d = 32'(cal_q);
                `ASP_OFS_STATUS: prdata_d = {26'h00_0000, frst_q, sel_f, self_f, tgt_q == asp_pkg::TGT_CAL,
                                             st_q};
                default:         prdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q        <= asp_pkg::ST_IDLE;
            tgt_q       <= asp_pkg::TGT_CTRL;
            gcnt_q      <= '0;
            sclk_q      <= 1'b1;
            sclk_oe_n_q <= 1'b1;
            sclk_prev_q <= 1'b1;
            sdo_q       <= 1'b0;
            sdo_oe_n_q  <= 1'b1;
            frst_q      <= 1'b0;
            ctrl_q      <= WORD_W'(`ASP_CTRL_RST);
            data_q      <= '0;
            cal_q       <= '0;
            pready_q    <= 1'b0;
            pslverr_q   <= 1'b0;
            prdata_q    <= 32'h0000_0000;
        end else begin
            st_q        <= st_d;
            tgt_q       <= tgt_d;
            gcnt_q      <= gcnt_d;
            sclk_q      <= sclk_d;
            sclk_oe_n_q <= sclk_oe_n_d;
            sclk_prev_q <= sclk_f;
            sdo_q       <= sh.sdo;
            sdo_oe_n_q  <= sdo_oe_n_d;
            frst_q      <= !sync_f;
            ctrl_q      <= ctrl_d;
            data_q      <= data_d;
            cal_q       <= cal_d;
            pready_q    <= pready_d;
            pslverr_q   <= pslverr_d;
            prdata_q    <= prdata_d;
        end
    end

    assign prdata             = prdata_q;
    assign pready             = pready_q;
    assign pslverr            = pslverr_q;
    assign sclk_o             = sclk_q;
    assign sclk_oe_n          = sclk_oe_n_q;
    assign sdata_o            = sdo_q;
    assign sdata_oe_n         = sdo_oe_n_q;
    assign burnout_current_en = ctrl_q[`ASP_CTRL_BURNOUT];
    assign comp_current_en    = ctrl_q[`ASP_CTRL_COMP];
    assign filter_reset       = frst_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_self_start;
        start && self_f;
    endsequence
    sequence s_ctrl_wr;
        apb_wr && paddr == `ASP_OFS_CTRL && !(st_q == asp_pkg::ST_WR && sh.done);
    endsequence

    property p_ext_no_drive;
        !self_f && $past(!self_f) |-> sclk_oe_n;
    endproperty
    a_ext_no_drive: assert property (p_ext_no_drive) else $error("clock driven in external mode");
    property p_self_drive;
        s_self_start ##1 (active && self_f && (st_q == asp_pkg::ST_RD ? !rcv_stb_f : !xmt_stb_f)) |=> !sclk_oe_n;
    endproperty
    a_self_drive: assert property (p_self_drive) else $error("self clock not started");
    property p_release_done;
        st_q == asp_pkg::ST_DONE |-> sclk_oe_n;
    endproperty
    a_release_done: assert property (p_release_done) else $error("clock held after word");
    property p_gapped_hold;
        st_q == asp_pkg::ST_WR && !xmt_stb_f && !sh.done |=> st_q == asp_pkg::ST_WR;
    endproperty
    a_gapped_hold: assert property (p_gapped_hold) else $error("gapped frame dropped");
    property p_sel_ctrl;
        start && !sel_f |=> tgt_q == asp_pkg::TGT_CTRL;
    endproperty
    a_sel_ctrl: assert property (p_sel_ctrl) else $error("wrong target for select low");
    property p_sync;
        !sync_f |=> filter_reset ##1 (filter_reset || sync_f);
    endproperty
    a_sync: assert property (p_sync) else $error("filter reset missing");
    property p_burnout;
        s_ctrl_wr |=> burnout_current_en == $past(pwdata[`ASP_CTRL_BURNOUT]);
    endproperty
    a_burnout: assert property (p_burnout) else $error("burnout enable not updated");
    property p_comp;
        s_ctrl_wr |=> comp_current_en == $past(pwdata[`ASP_CTRL_COMP]);
    endproperty
    a_comp: assert property (p_comp) else $error("comp enable not updated");
    property p_calsel;
        start && sel_f && ctrl_q[`ASP_CTRL_CALSEL] |=> tgt_q == asp_pkg::TGT_CAL;
    endproperty
    a_calsel: assert property (p_calsel) else $error("calibration not selected");
endmodule

// ===== asp_host_model.sv
/*
 Host serial port model: frame strobes, register select, external serial clock and data.
 Assumes the bench resolves the shared clock and data wires and runs pclk at 100 MHz.
*/
module asp_host_model (
    // Clock
    input  wire logic pclk,
    // Resolved pin levels
    input  wire logic sclk_w,
    input  wire logic sdata_w,
    // Host-driven pins
    output logic      sclk_h,
    output logic      sdata_h,
    output logic      receive_frame_strobe_n,
    output logic      transmit_frame_strobe_n,
    output logic      sel
);
    timeunit 1ns;
    timeprecision 1ps;
    logic in_wr = 1'b0;
    initial begin
        sclk_h = 1'b1;
        sdata_h = 1'b0;
        receive_frame_strobe_n = 1'b1;
        transmit_frame_strobe_n = 1'b1;
        sel = 1'b0;
    end
    // Released data line wanders so a stale level never passes for data
    always @(posedge pclk) if (!in_wr) sdata_h <= ~sdata_h;

    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask

    task automatic idle;
        receive_frame_strobe_n <= 1'b1;
        transmit_frame_strobe_n <= 1'b1;
        in_wr <= 1'b0;
        cyc(8);
    endtask

    // External clock frame, 160 ns period; gap idles the clock high after each byte
    task automatic ext_xfer(input logic rd, input logic s, input logic [23:0] wd, input int gap,
                            output logic [23:0] r);
        sel <= s;
        cyc(4);
        if (rd) receive_frame_strobe_n <= 1'b0;
        else transmit_frame_strobe_n <= 1'b0;
        in_wr <= !rd;
        cyc(10);
        for (int i = 23; i >= 0; i--) begin
            if (!rd) sdata_h <= wd[i];
            sclk_h <= 1'b0;
            cyc(8);
            r[i] = sdata_w;
            sclk_h <= 1'b1;
            cyc(8);
            if (i % 8 == 0) cyc(gap);
        end
        cyc(10);
        idle();
    endtask

    // Self-clocked read: counts rises of the device clock, stops after stop bits
    task automatic self_rd(input logic s, input int stop, output logic [23:0] r, output int n);
        logic last;
        n = 0;
        last = 1'b1;
        r = '0;
        sel <= s;
        cyc(4);
        receive_frame_strobe_n <= 1'b0;
        for (int k = 0; k < 600 && n < stop; k++) begin
            @(posedge pclk);
            if (sclk_w && !last) begin
                r = {r[22:0], sdata_w};
                n++;
            end
            last = sclk_w;
        end
        cyc(12);
    endtask
endmodule

// ===== asp_serial_port_tb.sv
/*
 Self-checking bench of the serial port controller: APB tasks, host serial model, pin resolution.
 Assumes one APB wait state and about four cycles of pin filtering in the design.
*/
`include "asp_defs.svh"
module asp_serial_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, mode, sync_n, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, sclk_o, sclk_oe_n, sdata_o, sdata_oe_n, burn, comp, frst;
    logic        sclk_h, sdata_h, receive_frame_strobe_n, transmit_frame_strobe_n, sel;
    logic [23:0] w;
    int          n, num_errors, n_compared;
    // Shared pins: the enabled party sets the level
    wire         sclk_w  = sclk_oe_n ? sclk_h : sclk_o;
    wire         sdata_w = sdata_oe_n ? sdata_h : sdata_o;

    asp_serial_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mode_self_clock(mode), .receive_frame_strobe_n(receive_frame_strobe_n),
        .transmit_frame_strobe_n(transmit_frame_strobe_n), .register_select(sel), .filter_sync_n(sync_n),
        .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe_n(sclk_oe_n), .sdata_i(sdata_w),
        .sdata_o(sdata_o), .sdata_oe_n(sdata_oe_n), .burnout_current_en(burn),
        .comp_current_en(comp), .filter_reset(frst));

    asp_host_model host (.pclk(pclk), .sclk_w(sclk_w), .sdata_w(sdata_w), .sclk_h(sclk_h),
        .sdata_h(sdata_h), .receive_frame_strobe_n(receive_frame_strobe_n),
        .transmit_frame_strobe_n(transmit_frame_strobe_n), .sel(sel));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rq, output logic re);
        int t;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        if (t >= 50) num_errors++;
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Device must never drive the clock while the strap selects an external clock
    always @(posedge pclk) if (presetn && !mode && sclk_oe_n !== 1'b1) begin
        num_errors++;
        $display("wrong value sclk_oe_n expected 1 seen %b", sclk_oe_n);
    end

    initial begin
        #300us;
        num_errors++;
        report_and_stop();
    end

    initial begin
        num_errors = 0;
        n_compared = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        mode = 1'b0;
        sync_n = 1'b1;
        cyc(8);
        presetn <= 1'b1;
        cyc(6);
        chk("idle pins", 32'h0000_0018, 32'({sclk_oe_n, sdata_oe_n, burn, comp, frst}));
        for (int v = 0; v < 4; v++) begin
            apb(1'b1, `ASP_OFS_CTRL, 32'(v), q, err);
            cyc(2);
            chk("current enables", 32'(v), 32'({comp, burn}));
        end
        apb(1'b0, `ASP_OFS_CTRL, 32'h0000_0000, q, err);
        chk("ctrl readback", 32'h0000_0003, q);
        chk("mapped slverr", 32'h0000_0000, 32'(err));
        apb(1'b0, 12'hFF0, 32'h0000_0000, q, err);
        chk("unmapped slverr", 32'h0000_0001, 32'(err));
        host.ext_xfer(1'b0, 1'b0, 24'h00_0001, 0, w);
        chk("serial ctrl write", 32'h0000_0001, 32'({comp, burn}));
        host.ext_xfer(1'b0, 1'b0, 24'h00_0002, 40, w);
        chk("gapped ctrl write", 32'h0000_0002, 32'({comp, burn}));
        host.ext_xfer(1'b0, 1'b1, 24'h00_0001, 0, w);
        apb(1'b0, `ASP_OFS_CTRL, 32'h0000_0000, q, err);
        chk("data target write", 32'h0000_0002, q);
        apb(1'b0, `ASP_OFS_DATA, 32'h0000_0000, q, err);
        chk("data write discarded", 32'h0000_0000, q);
        apb(1'b1, `ASP_OFS_DATA, 32'h00A5_C396, q, err);
        apb(1'b1, `ASP_OFS_CAL, 32'h003C_5AF0, q, err);
        host.ext_xfer(1'b1, 1'b1, 24'h00_0000, 0, w);
        chk("data read", 32'h00A5_C396, 32'(w));
        apb(1'b1, `ASP_OFS_CTRL, 32'h0000_0004, q, err);
        host.ext_xfer(1'b1, 1'b1, 24'h00_0000, 25, w);
        chk("cal read", 32'h003C_5AF0, 32'(w));
        host.ext_xfer(1'b1, 1'b0, 24'h00_0000, 0, w);
        chk("ctrl serial read", 32'h0000_0004, 32'(w));
        mode <= 1'b1;
        cyc(8);
        chk("self clock idle", 32'h0000_0001, 32'(sclk_oe_n));
        host.self_rd(1'b0, 24, w, n);
        chk("self bit count", 32'h0000_0018, 32'(n));
        chk("self word", 32'h0000_0004, 32'(w));
        chk("release at word end", 32'h0000_0001, 32'(sclk_oe_n));
        host.idle();
        host.self_rd(1'b0, 5, w, n);
        chk("clock driven in frame", 32'h0000_0000, 32'(sclk_oe_n));
        host.idle();
        chk("release on strobe high", 32'h0000_0001, 32'(sclk_oe_n));
        sync_n <= 1'b0;
        cyc(8);
        chk("filter reset", 32'h0000_0001, 32'(frst));
        apb(1'b0, `ASP_OFS_STATUS, 32'h0000_0000, q, err);
        chk("status", 32'h0000_0028, q);
        sync_n <= 1'b1;
        cyc(8);
        chk("filter released", 32'h0000_0000, 32'(frst));
        report_and_stop();
    end
endmodule
